// *** rtl/tasr_consts.svh ***
`ifndef TASR_CONSTS_SVH
`define TASR_CONSTS_SVH

// ============================================================
// Register offsets (byte addresses).
`define TASR_OFS_STATUS 8'h3c
`define TASR_OFS_SCLR 8'h40
`define TASR_OFS_IESET 8'h44
`define TASR_OFS_IECLR 8'h48
`define TASR_OFS_IMASK 8'h4c
`define TASR_OFS_LAUNCH 8'h50
`define TASR_OFS_COUNT 8'h54
`define TASR_OFS_BURST 8'h58
`define TASR_OFS_CTRL 8'h74
`define TASR_OFS_PAIRS 8'h78
`define TASR_OFS_MTX 8'h7c

// ============================================================
// Status bit positions.
`define TASR_B_DONE 9
`define TASR_B_READY 8
`define TASR_B_BLREQ 4
`define TASR_B_ACTIVE 3
`define TASR_B_CHANGE 2
`define TASR_B_CAL 1
`define TASR_B_EN 0

// ============================================================
// Masks, launch codes and reset values.
`define TASR_IRQ_BITS 32'h0000_0306
`define TASR_SEL_A 2'h0
`define TASR_SEL_B 2'h1
`define TASR_SEL_MTX 2'h2
`define TASR_SEL_BAD 2'h3
`define TASR_RST_WORD 32'h0000_0000
`define TASR_BURSTS_PER_WORD 4

`endif

// *** rtl/tasr_pkg.sv ***
package tasr_pkg;

    // ============================================================
    // Sequencer states.
    typedef enum logic [2:0] {
        TASR_IDLE,
        TASR_XWAIT,
        TASR_MEAS,
        TASR_HOLD
    } tasr_state_e;

    // Register port request.
    typedef struct packed {
        logic wr;
        logic rd;
        logic [7:0] addr;
        logic [31:0] wdata;
    } tasr_bus_s;

    // Measurement request to the analogue front end.
    typedef struct packed {
        logic start;
        logic matrix;
        logic [7:0] x;
        logic [7:0] y;
    } tasr_mreq_s;

    // Measurement answer from the analogue front end.
    typedef struct packed {
        logic done;
        logic [15:0] count;
    } tasr_mres_s;

    // Autonomous sensor levels and change pulse.
    typedef struct packed {
        logic active;
        logic calibrating;
        logic change;
    } tasr_auto_s;

    // Whole state of the block.
    typedef struct packed {
        tasr_state_e st;
        logic en;
        logic [7:0] div;
        logic [11:0] interval;
        logic [15:0] pairs;
        logic [15:0] mtx;
        logic [31:0] imask;
        logic done;
        logic ready;
        logic change;
        logic cal;
        logic [1:0] sel;
        logic [1:0] grp;
        logic [31:0] result;
        logic [2:0] cx;
        logic [2:0] cy;
        logic [2:0] bl_left;
        logic [7:0] psc;
        logic [11:0] gap;
        logic [31:0] rdata;
    } tasr_state_s;

endpackage

// *** rtl/tasr_readout.sv ***
// Our own choice: the address-and-strobe port.
`timescale 1ns/100ps
`include "tasr_consts.svh"

// Functional notes
// R01: Matrix X line starts are spaced by the sync interval in prescaled ticks.
// R02: Status bit 9 is zero during acquisition, one once complete.
// R03: Status bit 8 is set while a count result waits to be read.
// R04: Status bit 4 shows a matrix X line is waiting for burst lengths.
// R05: Status bit 3 mirrors the autonomous sensor active level.
// R06: Status bit 2 is a sticky flag on autonomous sensor status change.
// R07: Status bit 1 is one while the autonomous sensor calibrates.
// R08: Status bit 0 shows whether the whole module is enabled.
// R09: Status-clear ones clear bits 9, 8, 2, 1 and their interrupt requests.
// R10: Interrupt-enable ones set matching mask bits; zeros do nothing.
// R11: Interrupt-disable ones clear matching mask bits; zeros do nothing.
// R12: Interrupt mask resets to zero; one enables the matching interrupt.
// R13: A launch write starts group A, group B or matrix per type field.
// R14: Reading the launch register returns the last written type.
// R15: Count word holds Y in 31:24, index in 23:16, count in 15:0.
// R16: Index is the sensor pair for self results, X line for matrix.
// R17: Self results have Y zero and rising pair indices.
// R18: Matrix results step Y within fixed X, then move to next X.
// R19: Software writes burst lengths for each X line before it is acquired.
// R20: Interrupt output is high while any masked-in flag is set.
// R21: Reading the count register advances; ready drops when none remain. Here every count read clears ready; the next result sets it again.
module tasr_readout (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire tasr_pkg::tasr_bus_s bus_i,
    output logic [31:0] rdata_o,
    output tasr_pkg::tasr_mreq_s meas_req_o,
    input wire tasr_pkg::tasr_mres_s meas_res_i,
    input wire tasr_pkg::tasr_auto_s auto_i,
    output logic irq_o
);
    import tasr_pkg::*;

    tasr_state_s s;
    tasr_state_s next_s;
    logic [31:0] status;
    logic blreq;
    logic tick;
    logic wr_sclr;
    logic wr_launch;
    logic rd_count;
    logic [3:0] nx;
    logic [3:0] ny;
    logic [3:0] y0;
    logic [3:0] np;
    logic [7:0] grp_mask;
    logic [2:0] bl_need;

    // ============================================================
    // Index search
    // Lowest set mask bit at or above the start index; bit 3 flags a hit.
    function automatic logic [3:0] tasr_next(input logic [7:0] m, input logic [3:0] from);
        logic [3:0] r;
        r = 4'h0;
        for (int i = 7; i >= 0; i--) begin
            if (m[i] && (4'(i) >= from)) begin
                r = {1'b1, 3'(i)};
            end
        end
        return r;
    endfunction

    // ============================================================
    // Decode and derived status
    // Burst words needed per X line: one per four enabled Y lines, rounded up.
    assign blreq = (s.st == TASR_XWAIT) && (s.bl_left != 3'h0); // R04
    assign tick = (s.psc == s.div);
    assign wr_sclr = bus_i.wr && (bus_i.addr == `TASR_OFS_SCLR);
    assign wr_launch = bus_i.wr && (bus_i.addr == `TASR_OFS_LAUNCH);
    assign rd_count = bus_i.rd && (bus_i.addr == `TASR_OFS_COUNT);
    assign grp_mask = (s.grp == `TASR_SEL_B) ? s.pairs[15:8] : s.pairs[7:0];
    assign np = tasr_next(grp_mask, {1'b0, s.cx} + 4'h1); // R17
    assign ny = tasr_next(s.mtx[15:8], {1'b0, s.cy} + 4'h1); // R18
    assign nx = tasr_next(s.mtx[7:0], {1'b0, s.cx} + 4'h1); // R18
    assign y0 = tasr_next(s.mtx[15:8], 4'h0);
    assign bl_need = 3'((4'($countones(s.mtx[15:8])) + 4'h3) >> 2);

    // Status word; bits 7:5 and above 9 read as zero.
    always_comb begin
        status = `TASR_RST_WORD;
        status[`TASR_B_DONE] = s.done; // R02
        status[`TASR_B_READY] = s.ready; // R03
        status[`TASR_B_BLREQ] = blreq; // R04
        status[`TASR_B_ACTIVE] = auto_i.active; // R05
        status[`TASR_B_CHANGE] = s.change; // R06
        status[`TASR_B_CAL] = s.cal; // R07
        status[`TASR_B_EN] = s.en; // R08
    end

    // ============================================================
    // Next-state logic
    // Clears are applied first so that a hardware set in the same cycle wins.
    always_comb begin
        next_s = s;
        next_s.psc = tick ? 8'h00 : s.psc + 8'h01;
        if (tick && (s.gap != 12'h000)) begin
            next_s.gap = s.gap - 12'h001; // R01
        end

        // Register writes.
        if (bus_i.wr) begin
            case (bus_i.addr)
                `TASR_OFS_SCLR: begin
                    if (bus_i.wdata[`TASR_B_DONE]) next_s.done = 1'b0; // R09
                    if (bus_i.wdata[`TASR_B_READY]) next_s.ready = 1'b0; // R09
                    if (bus_i.wdata[`TASR_B_CHANGE]) next_s.change = 1'b0; // R09
                    if (bus_i.wdata[`TASR_B_CAL]) next_s.cal = 1'b0; // R09
                end
                `TASR_OFS_IESET: begin
                    next_s.imask = s.imask | (bus_i.wdata & `TASR_IRQ_BITS); // R10
                end
                `TASR_OFS_IECLR: begin
                    next_s.imask = s.imask & ~bus_i.wdata; // R11
                end
                `TASR_OFS_LAUNCH: begin
                    next_s.sel = bus_i.wdata[1:0]; // R14
                end
                `TASR_OFS_BURST: begin
                    if (s.bl_left != 3'h0) begin
                        next_s.bl_left = s.bl_left - 3'h1; // R19
                    end
                end
                `TASR_OFS_CTRL: begin
                    next_s.en = bus_i.wdata[0];
                    next_s.div = bus_i.wdata[15:8];
                    next_s.interval = bus_i.wdata[27:16];
                end
                `TASR_OFS_PAIRS: begin
                    next_s.pairs = bus_i.wdata[15:0];
                end
                `TASR_OFS_MTX: begin
                    next_s.mtx = bus_i.wdata[15:0];
                end
                default: begin
                end
            endcase
        end

        // Reading a result frees the holding word for the next one.
        if (rd_count) begin
            next_s.ready = 1'b0; // R21
        end

        // Autonomous sensor flags.
        if (auto_i.change) begin
            next_s.change = 1'b1; // R06
        end
        if (auto_i.calibrating) begin
            next_s.cal = 1'b1; // R07
        end

        // Acquisition sequencer.
        case (s.st)
            TASR_IDLE: begin
                if (wr_launch && s.en && (bus_i.wdata[1:0] != `TASR_SEL_BAD)) begin // R13
                    next_s.grp = bus_i.wdata[1:0];
                    next_s.done = 1'b0; // R02
                    next_s.ready = 1'b0;
                    next_s.gap = 12'h000;
                    next_s.cy = 3'h0;
                    if (bus_i.wdata[1:0] == `TASR_SEL_MTX) begin
                        next_s.cx = 3'(tasr_next(s.mtx[7:0], 4'h0));
                        next_s.cy = y0[2:0];
                        next_s.bl_left = bl_need;
                        if (!(tasr_next(s.mtx[7:0], 4'h0) >= 4'h8) || !y0[3]) begin
                            next_s.done = 1'b1;
                        end else begin
                            next_s.st = TASR_XWAIT;
                        end
                    end else begin
                        next_s.cx = 3'(tasr_next(bus_i.wdata[0] ? s.pairs[15:8] : s.pairs[7:0],
                                                 4'h0));
                        if (tasr_next(bus_i.wdata[0] ? s.pairs[15:8] : s.pairs[7:0],
                                      4'h0) >= 4'h8) begin
                            next_s.st = TASR_MEAS;
                        end else begin
                            next_s.done = 1'b1;
                        end
                    end
                end
            end
            TASR_XWAIT: begin
                // The line waits for its burst words and for the start spacing.
                if ((s.bl_left == 3'h0) && (s.gap == 12'h000)) begin // R01
                    next_s.st = TASR_MEAS;
                    next_s.gap = s.interval;
                end
            end
            TASR_MEAS: begin
                if (meas_res_i.done) begin
                    next_s.result[31:24] = (s.grp == `TASR_SEL_MTX) ? {5'h00, s.cy} : 8'h00; // R15
                    next_s.result[23:16] = {5'h00, s.cx}; // R16
                    next_s.result[15:0] = meas_res_i.count; // R15
                    next_s.ready = 1'b1; // R03
                    next_s.st = TASR_HOLD;
                end
            end
            TASR_HOLD: begin
                // The front end is stalled until software has taken the result.
                if (!s.ready) begin
                    if (s.grp != `TASR_SEL_MTX) begin
                        if (np[3]) begin
                            next_s.cx = np[2:0]; // R17
                            next_s.st = TASR_MEAS;
                        end else begin
                            next_s.done = 1'b1; // R02
                            next_s.st = TASR_IDLE;
                        end
                    end else if (ny[3]) begin
                        next_s.cy = ny[2:0]; // R18
                        next_s.st = TASR_MEAS;
                    end else if (nx[3]) begin
                        next_s.cx = nx[2:0]; // R18
                        next_s.cy = y0[2:0];
                        next_s.bl_left = bl_need;
                        next_s.st = TASR_XWAIT;
                    end else begin
                        next_s.done = 1'b1; // R02
                        next_s.st = TASR_IDLE;
                    end
                end
            end
            default: begin
                next_s.st = TASR_IDLE;
            end
        endcase

        // Disabling the module abandons any acquisition in flight.
        if (!next_s.en) begin
            next_s.st = TASR_IDLE;
            next_s.bl_left = 3'h0;
        end

        // Read data for the cycle after the read strobe.
        next_s.rdata = `TASR_RST_WORD;
        if (bus_i.rd) begin
            case (bus_i.addr)
                `TASR_OFS_STATUS: next_s.rdata = status;
                `TASR_OFS_IMASK: next_s.rdata = s.imask;
                `TASR_OFS_LAUNCH: next_s.rdata = {30'h0000_0000, s.sel}; // R14
                `TASR_OFS_COUNT: next_s.rdata = s.result;
                `TASR_OFS_CTRL: next_s.rdata = {4'h0, s.interval, s.div, 7'h00, s.en};
                `TASR_OFS_PAIRS: next_s.rdata = {16'h0000, s.pairs};
                `TASR_OFS_MTX: next_s.rdata = {16'h0000, s.mtx};
                default: next_s.rdata = `TASR_RST_WORD;
            endcase
        end
    end

    // ============================================================
    // State register
    // Synchronous reset brings every field, the mask included, to zero.
    // A clear and a hardware set in one cycle are resolved before this register.
    always_ff @(posedge clk_i) begin
        if (srst_i) begin
            s <= '0; // R12
        end else begin
            s <= next_s;
        end
    end

    // ============================================================
    // Outputs
    // The request strobe is a level for the whole measurement.
    assign rdata_o = s.rdata;
    assign meas_req_o.start = (s.st == TASR_MEAS);
    assign meas_req_o.matrix = (s.grp == `TASR_SEL_MTX);
    assign meas_req_o.x = {5'h00, s.cx};
    assign meas_req_o.y = {5'h00, s.cy};
    assign irq_o = |(status & s.imask & `TASR_IRQ_BITS); // R20

    // ============================================================
    // Checks
    // Properties are blind during reset; the mask check watches the reset itself.
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (srst_i);

    space_xline_a: assert property ( // R01
        (s.st == TASR_XWAIT) && (s.gap != 12'h000) |=> s.st != TASR_MEAS)
        else $error("X line started before the spacing ran out");
    launch_busy_a: assert property ( // R02
        (s.st == TASR_IDLE) && wr_launch && s.en && (bus_i.wdata[1:0] != 2'h3)
            && !wr_sclr |=> !s.done || (s.st == TASR_IDLE))
        else $error("Completion flag stayed set after a launch");
    ready_set_a: assert property ( // R03
        (s.st == TASR_MEAS) && meas_res_i.done && s.en |=> s.ready && (s.st == TASR_HOLD))
        else $error("Result captured without ready flag");
    blreq_state_a: assert property ( // R04
        status[`TASR_B_BLREQ] |-> (s.st == TASR_XWAIT))
        else $error("Burst request outside X line wait");
    change_set_a: assert property ( // R06
        auto_i.change |=> s.change)
        else $error("Sensor change not flagged");
    cal_set_a: assert property ( // R07
        auto_i.calibrating |=> status[`TASR_B_CAL])
        else $error("Calibration not shown");
    sclr_done_a: assert property ( // R09
        wr_sclr && bus_i.wdata[`TASR_B_DONE] && (s.st != TASR_HOLD) |=> !s.done)
        else $error("Completion flag survived a clear");
    ieset_a: assert property ( // R10
        bus_i.wr && (bus_i.addr == `TASR_OFS_IESET) && bus_i.wdata[9] |=> s.imask[9])
        else $error("Mask bit not set");
    ieclr_a: assert property ( // R11
        bus_i.wr && (bus_i.addr == `TASR_OFS_IECLR) && bus_i.wdata[8] |=> !s.imask[8])
        else $error("Mask bit not cleared");
    mask_reset_a: assert property (@(posedge clk_i) disable iff (1'b0) // R12
        srst_i |=> (s.imask == 32'h0000_0000))
        else $error("Mask not zero after reset");
    launch_read_a: assert property ( // R14
        wr_launch ##1 (bus_i.rd && (bus_i.addr == `TASR_OFS_LAUNCH))
            |=> rdata_o[1:0] == $past(bus_i.wdata[1:0], 2))
        else $error("Launch read does not return last type");
    self_word_a: assert property ( // R17
        (s.st == TASR_MEAS) && meas_res_i.done && (s.grp != 2'h2) && s.en
            |=> (s.result[31:24] == 8'h00) && (s.result[15:0] == $past(meas_res_i.count)))
        else $error("Self result word malformed");
    read_drop_a: assert property ( // R21
        rd_count && (s.st != TASR_MEAS) |=> !s.ready)
        else $error("Ready flag held after read");
    irq_out_a: assert property ( // R20
        s.done && s.imask[9] |-> irq_o)
        else $error("Interrupt missing for enabled flag");

    // Refused launches and the spacing load at each X line start.
    launch_refuse_a: assert property ( // R13
        wr_launch && (s.st == TASR_IDLE) && (!s.en || (bus_i.wdata[1:0] == `TASR_SEL_BAD))
            |=> s.st == TASR_IDLE)
        else $error("Refused launch started an acquisition");
    gap_load_a: assert property ( // R01
        (s.st == TASR_XWAIT) ##1 (s.st == TASR_MEAS) |-> s.gap == $past(s.interval))
        else $error("Spacing not loaded at X line start");

    // Result words and the visiting order of pairs and lines.
    matrix_word_a: assert property ( // R16
        (s.st == TASR_MEAS) && meas_res_i.done && (s.grp == `TASR_SEL_MTX) && s.en
            |=> s.result[31:16] == {5'h00, s.cy, 5'h00, s.cx})
        else $error("Matrix result word malformed");
    pair_rise_a: assert property ( // R17
        (s.st == TASR_HOLD) && !s.ready && (s.grp != `TASR_SEL_MTX) && np[3]
            |=> s.cx > $past(s.cx))
        else $error("Pair index did not rise");
    y_step_a: assert property ( // R18
        (s.st == TASR_HOLD) && !s.ready && (s.grp == `TASR_SEL_MTX) && ny[3]
            |=> (s.cx == $past(s.cx)) && (s.cy > $past(s.cy)))
        else $error("Matrix step left its X line");
    self_done_a: assert property ( // R02
        (s.st == TASR_HOLD) && !s.ready && (s.grp != `TASR_SEL_MTX) && !np[3] |=> s.done)
        else $error("Completion missing after last pair");

    // Flag clears, the burst handshake and the enable bit.
    sclr_ready_a: assert property ( // R09
        wr_sclr && bus_i.wdata[`TASR_B_READY] && (s.st != TASR_MEAS) |=> !s.ready)
        else $error("Ready flag survived a clear");
    sclr_auto_a: assert property ( // R09
        wr_sclr && bus_i.wdata[`TASR_B_CHANGE] && !auto_i.change |=> !s.change)
        else $error("Change flag survived a clear");
    sclr_cal_a: assert property ( // R09
        wr_sclr && bus_i.wdata[`TASR_B_CAL] && !auto_i.calibrating |=> !status[`TASR_B_CAL])
        else $error("Calibration flag survived a clear");
    burst_done_a: assert property ( // R04
        bus_i.wr && (bus_i.addr == `TASR_OFS_BURST) && (s.bl_left == 3'h1)
            |=> !status[`TASR_B_BLREQ])
        else $error("Burst request stayed after the last word");
    en_status_a: assert property ( // R08
        bus_i.wr && (bus_i.addr == `TASR_OFS_CTRL)
            |=> status[`TASR_B_EN] == $past(bus_i.wdata[0]))
        else $error("Enable bit not shown in status");

endmodule

// *** tb/tasr_sensor_model.sv ***
`timescale 1ns/100ps

// ============================================================
// Sensor side: answers each measurement request after a set delay.
module tasr_sensor_model (
    input wire logic clk_i,
    input wire logic srst_i,
    input wire tasr_pkg::tasr_mreq_s meas_req_i,
    input wire logic [7:0] delay_i,
    input wire logic [15:0] count_i,
    output tasr_pkg::tasr_mres_s meas_res_o
);
    import tasr_pkg::*;
    logic [7:0] wait_cnt;
    logic spent;
    logic done;
    logic [15:0] held;

    // One done pulse per request; spent blocks a second pulse until start drops.
    always_ff @(posedge clk_i) begin
        if (srst_i || !meas_req_i.start) begin
            wait_cnt <= 8'h00;
            spent <= 1'b0;
            done <= 1'b0;
        end else if (done) begin
            done <= 1'b0;
            spent <= 1'b1;
        end else if (!spent && wait_cnt >= delay_i) begin
            done <= 1'b1;
            held <= count_i;
        end else if (!spent) begin
            wait_cnt <= wait_cnt + 8'h01;
        end
    end

    // Outside the done cycle the count shows the inverse, so a stale sample is caught.
    assign meas_res_o.done = done;
    assign meas_res_o.count = done ? held : ~held;
endmodule

// *** tb/touch_acq_status_readout_test.sv ***
`timescale 1ns/100ps
`include "tasr_consts.svh"

module touch_acq_status_readout_test;
    import tasr_pkg::*;
    localparam int DIV = 1;
    localparam int IVL = 120; // Long enough that the spacing, not software, paces X lines.
    logic clk_i = 1'b0;
    logic srst_i = 1'b1;
    tasr_bus_s bus = '0;
    tasr_auto_s auto = '0;
    tasr_mreq_s mreq;
    tasr_mres_s mres;
    logic [31:0] rdata;
    logic irq;
    logic [7:0] delay = 8'h01;
    logic [15:0] cur_cnt = 16'h1234;
    logic [31:0] seed = 32'd39052;
    logic [31:0] exp_q[$];
    logic rd_pend = 1'b0;
    logic start_d = 1'b0;
    logic [7:0] last_x = 8'hff;
    int t_x = -1;
    int cyc = 0;
    int error_cnt = 0;
    int num_checks = 0;

    // ============================================================
    // Clock, design and sensor model.
    always #25 clk_i = ~clk_i;

    tasr_readout i_tasr_readout (.clk_i(clk_i), .srst_i(srst_i), .bus_i(bus), .rdata_o(rdata),
        .meas_req_o(mreq), .meas_res_i(mres), .auto_i(auto), .irq_o(irq));

    tasr_sensor_model i_tasr_sensor_model (.clk_i(clk_i), .srst_i(srst_i), .meas_req_i(mreq),
        .delay_i(delay), .count_i(cur_cnt), .meas_res_o(mres));

    // ============================================================
    // Helpers.
    function logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    task chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task complete_run();
        if (error_cnt == 0 && num_checks > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    // Each access holds the bus for one edge; the next task or idle releases it.
    task wr(input logic [7:0] a, input logic [31:0] d);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk_i);
    endtask

    task rd(input logic [7:0] a, input logic [31:0] exp);
        exp_q.push_back(exp);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0000_0000};
        @(posedge clk_i);
    endtask

    task idle(input int n);
        bus <= '0;
        repeat (n) @(posedge clk_i);
    endtask

    task irq_is(input logic e);
        bus <= '0;
        @(negedge clk_i);
        chk("irq", {31'h0, irq}, {31'h0, e});
        @(posedge clk_i);
    endtask

    // Waits for the edge at which the design takes a sensor result.
    task wait_done();
        int n;
        bus <= '0;
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
        end while (mres.done !== 1'b1 && n < 400);
        if (n >= 400)
            chk("done wait", 32'h0, 32'h1);
    endtask

    task self_run(input logic [1:0] grp);
        logic [7:0] m;
        m = 8'(rnd()) | 8'h10;
        delay <= 8'(rnd() & 32'h0000_000f) + 8'h01;
        wr(`TASR_OFS_PAIRS, grp[0] ? {16'h0, m, 8'h00} : {24'h0, m});
        wr(`TASR_OFS_LAUNCH, {30'h0, grp});
        for (int p = 0; p < 8; p++) begin
            if (m[p]) begin
                wait_done();
                chk("pair", {24'h0, mreq.x}, 32'(p));
                rd(`TASR_OFS_STATUS, 32'h0000_0101);
                rd(`TASR_OFS_COUNT, {8'h00, 8'(p), cur_cnt});
                cur_cnt <= 16'(rnd());
            end
        end
        idle(1);
        rd(`TASR_OFS_STATUS, 32'h0000_0201);
        irq_is(1'b1);
        rd(`TASR_OFS_LAUNCH, {30'h0, grp});
        wr(`TASR_OFS_SCLR, 32'h0000_0300);
        irq_is(1'b0);
    endtask

    // ============================================================
    // Result watcher: read data stand in the cycle after the strobe.
    always @(posedge clk_i) begin
        cyc++;
        if (rd_pend)
            chk("rdata", rdata, exp_q.pop_front());
        rd_pend <= bus.rd;
        if (mreq.start && !start_d && mreq.matrix && mreq.x != last_x) begin
            if (t_x >= 0)
                chk("x spacing", 32'((cyc - t_x) >= IVL * (DIV + 1) - DIV
                    && (cyc - t_x) <= IVL * (DIV + 1) + DIV + 4), 32'h1);
            last_x <= mreq.x;
            t_x <= cyc;
        end
        start_d <= mreq.start;
        if (cyc == 20000) begin
            error_cnt++;
            complete_run();
        end
    end

    // ============================================================
    // Main sequence.
    initial begin
        logic [7:0] xm;
        logic [7:0] ym;
        int ny;
        repeat (16) @(posedge clk_i);
        srst_i <= 1'b0;
        rd(`TASR_OFS_STATUS, 32'h0000_0000);
        rd(`TASR_OFS_IMASK, 32'h0000_0000);
        rd(`TASR_OFS_COUNT, 32'h0000_0000);
        rd(8'h30, 32'h0000_0000);
        // A launch while disabled must not start the sensors.
        wr(`TASR_OFS_PAIRS, 32'h0000_0001);
        wr(`TASR_OFS_LAUNCH, 32'h0000_0000);
        idle(4);
        chk("start off", {31'h0, mreq.start}, 32'h0);
        wr(`TASR_OFS_IESET, 32'h0000_0306);
        wr(`TASR_OFS_IECLR, 32'h0000_0004);
        wr(`TASR_OFS_IESET, 32'h0000_0000);
        wr(`TASR_OFS_IECLR, 32'h0000_0000);
        rd(`TASR_OFS_IMASK, 32'h0000_0302);
        wr(`TASR_OFS_CTRL, {4'h0, 12'(IVL), 8'(DIV), 7'h00, 1'b1});
        rd(`TASR_OFS_STATUS, 32'h0000_0001);
        // Autonomous sensor flags and their interrupt.
        auto <= 3'b111;
        idle(1);
        auto <= 3'b100;
        idle(1);
        rd(`TASR_OFS_STATUS, 32'h0000_000f);
        irq_is(1'b1);
        wr(`TASR_OFS_SCLR, 32'h0000_0002);
        irq_is(1'b0);
        wr(`TASR_OFS_SCLR, 32'h0000_0000);
        rd(`TASR_OFS_STATUS, 32'h0000_000d);
        wr(`TASR_OFS_IESET, 32'h0000_0004);
        irq_is(1'b1);
        wr(`TASR_OFS_SCLR, 32'h0000_0004);
        auto <= 3'b000;
        idle(1);
        rd(`TASR_OFS_STATUS, 32'h0000_0001);
        // The undefined type is stored but starts nothing.
        wr(`TASR_OFS_LAUNCH, 32'h0000_0003);
        rd(`TASR_OFS_LAUNCH, 32'h0000_0003);
        idle(2);
        chk("start bad", {31'h0, mreq.start}, 32'h0);
        rd(`TASR_OFS_LAUNCH, 32'h0000_0003);
        self_run(2'b00);
        self_run(2'b01);
        // Matrix: at least two X lines and five Y lines, so two burst words per line.
        xm = 8'(rnd()) | 8'h81;
        ym = 8'(rnd()) | 8'h1f;
        ny = $countones(ym);
        wr(`TASR_OFS_MTX, {16'h0, ym, xm});
        wr(`TASR_OFS_LAUNCH, 32'h0000_0002);
        for (int x = 0; x < 8; x++) begin
            if (xm[x]) begin
                idle(1);
                rd(`TASR_OFS_STATUS, 32'h0000_0011);
                for (int b = 0; b < (ny + 3) / 4; b++)
                    wr(`TASR_OFS_BURST, rnd());
                for (int y = 0; y < 8; y++) begin
                    if (ym[y]) begin
                        wait_done();
                        chk("xy", {16'h0, mreq.x, mreq.y}, {16'h0, 8'(x), 8'(y)});
                        rd(`TASR_OFS_STATUS, 32'h0000_0101);
                        rd(`TASR_OFS_COUNT, {8'(y), 8'(x), cur_cnt});
                        cur_cnt <= 16'(rnd());
                    end
                end
            end
        end
        idle(1);
        rd(`TASR_OFS_STATUS, 32'h0000_0201);
        idle(3);
        complete_run();
    end
endmodule
